// ---- core/cpu_flags_pkg.sv ----
package cpu_flags_pkg;

    // Register map, word index on the plain register port
    localparam logic [3:0] PROCESSOR_FLAGS_OFFSET = 4'h0;
    localparam logic [3:0] LAST_RESULT_OFFSET = 4'h1;

    // Flag positions inside processor_flags
    localparam int CARRY_BIT = 0;
    localparam int NIBBLE_CARRY_BIT = 1;
    localparam int RESULT_NULL_BIT = 2;
    localparam int SIGNED_RANGE_BIT = 3;
    localparam int SLEEP_ENTERED_BIT = 4;
    localparam int WATCHDOG_EXPIRED_BIT = 5;
    localparam int COMPOUND_NULL_BIT = 6;
    localparam int SIGN_XOR_BIT = 7;

    // Reset values; arithmetic flags are undefined, held at zero here
    localparam logic [7:0] PROCESSOR_FLAGS_RESET = 8'h00;
    localparam logic [7:0] LAST_RESULT_RESET = 8'h00;
    localparam logic [7:0] READ_DATA_IDLE = 8'h00;

    // Bits software may write
    localparam logic [7:0] SOFTWARE_WRITE_MASK = 8'hcf;

    // Operation codes presented by the execution logic
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_ADD = 4'h1,
        OP_ADC = 4'h2,
        OP_SUB = 4'h3,
        OP_SBC = 4'h4,
        OP_AND = 4'h5,
        OP_OR = 4'h6,
        OP_XOR = 4'h7,
        OP_RLC = 4'h8,
        OP_RRC = 4'h9
    } alu_op_t;

endpackage

// ---- core/carry_chain_adder.sv ----
`timescale 1ns/1ps

// 8-bit adder that exposes the nibble carry and the carries into and out of the top bit
module carry_chain_adder #(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] addend_a,
    input wire logic [WIDTH-1:0] addend_b,
    input wire logic carry_in,
    output logic [WIDTH-1:0] sum,
    output logic nibble_carry,
    output logic carry_into_msb,
    output logic carry_out
);

    initial begin
        if (WIDTH < 8) begin
            $error("carry_chain_adder needs at least 8 bits");
        end
    end

    logic [4:0] low_sum;
    logic [WIDTH-1:0] low_part_sum;
    logic [WIDTH:0] full_sum;

    // Partial sums give the intermediate carries without a ripple model
    always_comb begin
        low_sum = {1'b0, addend_a[3:0]} + {1'b0, addend_b[3:0]} + {4'h0, carry_in};
        low_part_sum = {1'b0, addend_a[WIDTH-2:0]} + {1'b0, addend_b[WIDTH-2:0]}
            + {{(WIDTH-1){1'b0}}, carry_in};
        full_sum = {1'b0, addend_a} + {1'b0, addend_b} + {{WIDTH{1'b0}}, carry_in};
        sum = full_sum[WIDTH-1:0];
        nibble_carry = low_sum[4];
        carry_into_msb = low_part_sum[WIDTH-1];
        carry_out = full_sum[WIDTH];
    end

endmodule // carry_chain_adder

// ---- core/cpu_status_flags.sv ----
`timescale 1ns/1ps

// Contract
// - Carry set on add carry or sub no-borrow
// - Rotate-through-carry uses and updates carry
// - Nibble carry from low nibble carry/no-borrow
// - Null flag set on zero result of arithmetic and logic ops; rotates leave it
// - Signed range flag is carry7 xor carry8
// - Sleep flag cleared by power-up/kick, set by sleep
// - Watchdog flag cleared by power-up/kick/sleep, set on timeout
// - Software writes never touch watchdog and sleep flags
// - Sign-xor flag is range flag xor result msb
// - No automatic save on interrupt or call
// - Eight-bit register; watchdog/sleep flags reset zero
// - Compound null per class; sub equals null flag
module cpu_status_flags
    import cpu_flags_pkg::*;
#(
    parameter int ADDR_WIDTH = 4
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [ADDR_WIDTH-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [7:0] reg_rdata,
    input wire logic op_valid,
    input wire cpu_flags_pkg::alu_op_t op_code,
    input wire logic [7:0] op_a,
    input wire logic [7:0] op_b,
    output logic [7:0] result_out,
    output logic result_valid,
    input wire logic kick_watchdog_instr,
    input wire logic sleep_instr,
    input wire logic watchdog_timeout,
    output logic [7:0] flags_out
);
    import cpu_flags_pkg::*;

    // Refuse address widths the 16-bit compare cannot serve
    initial begin
        if (ADDR_WIDTH < 1 || ADDR_WIDTH > 16) begin
            $error("cpu_status_flags: ADDR_WIDTH must lie in 1..16");
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    // Address match against a 4-bit map index, wider upper bits must be zero
    function automatic logic addr_hit(input logic [ADDR_WIDTH-1:0] addr,
                                      input logic [3:0] offset);
        logic [15:0] wide_addr;
        wide_addr = 16'h0000;
        wide_addr[ADDR_WIDTH-1:0] = addr;
        return wide_addr == {12'h000, offset};
    endfunction

    // Subtract-type operations share the inverted-operand adder path
    function automatic logic is_subtract(input alu_op_t code);
        return (code == OP_SUB) || (code == OP_SBC);
    endfunction

    // Classes that rewrite the full arithmetic flag set
    function automatic logic is_arith(input alu_op_t code);
        return (code == OP_ADD) || (code == OP_ADC) || is_subtract(code);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // State

    logic [7:0] flags_reg;
    logic [7:0] flags_next;
    logic [7:0] result_reg;
    logic [7:0] result_next;
    logic result_valid_reg;
    logic result_valid_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    ////////////////////////////////////////////////////////////////////////////////
    // Arithmetic path

    logic [7:0] adder_b;
    logic adder_cin;
    logic [7:0] adder_sum;
    logic adder_c4;
    logic adder_c7;
    logic adder_c8;

    // Carry set means no borrow, so SBC feeds the stored carry straight
    // in and a multi-byte subtract needs no inversion in software
    // Subtraction as a plus not-b plus carry, so carry out means no borrow
    always_comb begin
        adder_b = op_b;
        adder_cin = 1'b0;
        // Plain add with no carry in unless decoded below
        unique case (op_code)
            OP_ADC: begin
                adder_cin = flags_reg[CARRY_BIT];
            end
            OP_SUB: begin
                adder_b = ~op_b;
                adder_cin = 1'b1;
            end
            OP_SBC: begin
                adder_b = ~op_b;
                adder_cin = flags_reg[CARRY_BIT];
            end
            default: begin
                adder_b = op_b;
                adder_cin = 1'b0;
            end
        endcase
    end

    // One shared adder serves add, subtract and their carry variants
    carry_chain_adder #(
        .WIDTH(8)
    ) u_adder (
        .addend_a(op_a),
        .addend_b(adder_b),
        .carry_in(adder_cin),
        .sum(adder_sum),
        .nibble_carry(adder_c4),
        .carry_into_msb(adder_c7),
        .carry_out(adder_c8)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Operation result and flag outcome

    // Decoded per operation, merged into the flags under op_touch
    logic [7:0] op_result;
    logic [7:0] op_flags;
    logic [7:0] op_touch;
    logic op_range;

    // Each operation class names the flags it rewrites in op_touch
    always_comb begin
        op_result = adder_sum;
        op_flags = flags_reg;
        op_touch = 8'h00;
        op_range = is_arith(op_code) && (adder_c7 ^ adder_c8);
        unique case (op_code)
            OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
                op_result = adder_sum;
                op_flags[CARRY_BIT] = adder_c8;
                op_flags[NIBBLE_CARRY_BIT] = adder_c4;
                op_flags[RESULT_NULL_BIT] = (adder_sum == 8'h00);
                op_flags[SIGNED_RANGE_BIT] = op_range;
                op_flags[SIGN_XOR_BIT] = op_range ^ adder_sum[7];
                op_touch[CARRY_BIT] = 1'b1;
                op_touch[NIBBLE_CARRY_BIT] = 1'b1;
                op_touch[RESULT_NULL_BIT] = 1'b1;
                op_touch[SIGNED_RANGE_BIT] = 1'b1;
                op_touch[SIGN_XOR_BIT] = 1'b1;
            end
            OP_AND, OP_OR, OP_XOR: begin
                if (op_code == OP_AND) begin
                    op_result = op_a & op_b;
                end else if (op_code == OP_OR) begin
                    op_result = op_a | op_b;
                end else begin
                    op_result = op_a ^ op_b;
                end
                op_flags[RESULT_NULL_BIT] = (op_result == 8'h00);
                op_touch[RESULT_NULL_BIT] = 1'b1;
            end
            OP_RLC: begin
                // Carry sits as a ninth bit below bit 0
                op_result = {op_a[6:0], flags_reg[CARRY_BIT]};
                op_flags[CARRY_BIT] = op_a[7];
                op_touch[CARRY_BIT] = 1'b1;
            end
            OP_RRC: begin
                // Mirror image: carry enters at bit 7
                op_result = {flags_reg[CARRY_BIT], op_a[7:1]};
                op_flags[CARRY_BIT] = op_a[0];
                op_touch[CARRY_BIT] = 1'b1;
            end
            default: begin
                // No-op: nothing rewritten
                op_result = result_reg;
                op_touch = 8'h00;
            end
        endcase
        // Plain subtract copies the null flag; with borrow it chains across bytes
        if (op_code == OP_SUB) begin
            op_flags[COMPOUND_NULL_BIT] = op_flags[RESULT_NULL_BIT];
            op_touch[COMPOUND_NULL_BIT] = 1'b1;
        end else if (op_code == OP_SBC) begin
            op_flags[COMPOUND_NULL_BIT] = op_flags[RESULT_NULL_BIT]
                & flags_reg[COMPOUND_NULL_BIT];
            op_touch[COMPOUND_NULL_BIT] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next flag value

    // Strobe decode for the flag register
    logic status_write;
    logic op_active;

    // Operation beats a simultaneous software write on the bits it touches
    always_comb begin
        status_write = reg_we && addr_hit(reg_addr, PROCESSOR_FLAGS_OFFSET);
        op_active = op_valid && (op_code != OP_NONE);
        // Priority, lowest first: hold, write, operation, events
        flags_next = flags_reg;
        if (status_write) begin
            // Masked: watchdog and sleep bits keep their value
            flags_next = (flags_reg & ~SOFTWARE_WRITE_MASK)
                | (reg_wdata & SOFTWARE_WRITE_MASK);
        end
        // Applied after the write so it wins on the bits it rewrites
        if (op_active) begin
            flags_next = (flags_next & ~op_touch) | (op_flags & op_touch);
        end
        // Sleep flag: set wins over a kick in the same cycle
        if (kick_watchdog_instr) begin
            flags_next[SLEEP_ENTERED_BIT] = 1'b0;
        end
        if (sleep_instr) begin
            flags_next[SLEEP_ENTERED_BIT] = 1'b1;
        end
        // Watchdog flag: a timeout is never lost to a same-cycle clear
        if (kick_watchdog_instr || sleep_instr) begin
            flags_next[WATCHDOG_EXPIRED_BIT] = 1'b0;
        end
        if (watchdog_timeout) begin
            flags_next[WATCHDOG_EXPIRED_BIT] = 1'b1;
        end
    end

    // Only operations, writes and instruction events move the flags;
    // nothing here pushes them on interrupt or call
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flags_reg <= PROCESSOR_FLAGS_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Result register

    // Result held so the execution logic samples a stable byte
    always_comb begin
        result_next = result_reg;
        result_valid_next = 1'b0;
        // A refused no-op keeps the old result and raises no valid
        if (op_active) begin
            result_next = op_result;
            result_valid_next = 1'b1;
        end
    end

    // Register stage; valid drops unless a new op was accepted
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            result_reg <= LAST_RESULT_RESET;
            result_valid_reg <= 1'b0;
        end else begin
            result_reg <= result_next;
            result_valid_reg <= result_valid_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register read port

    // Read data stand only in the cycle after the strobe; idle reads zero
    always_comb begin
        rdata_next = READ_DATA_IDLE;
        if (reg_re) begin
            if (addr_hit(reg_addr, PROCESSOR_FLAGS_OFFSET)) begin
                rdata_next = flags_reg;
            end else if (addr_hit(reg_addr, LAST_RESULT_OFFSET)) begin
                rdata_next = result_reg;
            end else begin
                rdata_next = READ_DATA_IDLE;
            end
        end
    end

    // Registered, so a read never sees a same-cycle update
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_reg <= READ_DATA_IDLE;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Outputs straight from flip-flops
    assign reg_rdata = rdata_reg;
    assign result_out = result_reg;
    assign result_valid = result_valid_reg;
    assign flags_out = flags_reg;

endmodule // cpu_status_flags

// ---- dv/exec_model.sv ----
`timescale 1ns/1ps

// Execution side: one-cycle strobes per instruction or event
module exec_model
    import cpu_flags_pkg::*;
(
    input wire logic clk,
    output logic op_valid,
    output cpu_flags_pkg::alu_op_t op_code,
    output logic [7:0] op_a,
    output logic [7:0] op_b,
    output logic [2:0] evt
);
    // Idle from time zero
    initial begin
        op_valid = 1'b0;
        op_code = OP_NONE;
        op_a = 8'h00;
        op_b = 8'h00;
        evt = 3'b000;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Strobe high for exactly one sampling edge
    task automatic issue(input alu_op_t c, input logic [7:0] a, input logic [7:0] b);
        @(posedge clk);
        op_valid <= 1'b1;
        op_code <= c;
        op_a <= a;
        op_b <= b;
        @(posedge clk);
        op_valid <= 1'b0;
        op_a <= ~a; // Stale operands must not look valid
        op_b <= ~b;
    endtask
    // Bit 0 kick, bit 1 sleep, bit 2 timeout
    task automatic pulse(input logic [2:0] e);
        @(posedge clk);
        evt <= e;
        @(posedge clk);
        evt <= 3'b000;
    endtask
endmodule // exec_model

// ---- dv/cpu_status_flags_monitor.sv ----
`timescale 1ns/1ps

// Port-level flag checks
module cpu_status_flags_monitor
    import cpu_flags_pkg::*;
#(
    parameter int ADDR_WIDTH = 4
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [ADDR_WIDTH-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    input wire logic [7:0] reg_rdata,
    input wire logic op_valid,
    input wire cpu_flags_pkg::alu_op_t op_code,
    input wire logic [7:0] op_a,
    input wire logic [7:0] op_b,
    input wire logic [7:0] result_out,
    input wire logic result_valid,
    input wire logic kick_watchdog_instr,
    input wire logic sleep_instr,
    input wire logic watchdog_timeout,
    input wire logic [7:0] flags_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic quiet;
    // No op or event competing with a software write
    assign quiet = !op_valid && !kick_watchdog_instr && !sleep_instr && !watchdog_timeout;
    ////////////////////////////////////////////////////////////////////////////////
    property p_wdog_set; watchdog_timeout |=> flags_out[5]; endproperty
    a_wdog_set: assert property (p_wdog_set) else $error("timeout flag not set");
    property p_sleep; sleep_instr && !watchdog_timeout |=> flags_out[5:4] == 2'b01; endproperty
    a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
    property p_kick;
        kick_watchdog_instr && !sleep_instr && !watchdog_timeout |=> flags_out[5:4] == 2'b00;
    endproperty
    a_kick: assert property (p_kick) else $error("kick flags wrong");
    property p_swwr;
        reg_we && reg_addr == PROCESSOR_FLAGS_OFFSET && quiet |=> flags_out ==
            (($past(flags_out) & 8'h30) | ($past(reg_wdata) & SOFTWARE_WRITE_MASK));
    endproperty
    a_swwr: assert property (p_swwr) else $error("write result wrong");
    property p_null;
        op_valid && op_code inside {OP_AND, OP_OR, OP_XOR} |=> flags_out[2] == (result_out == 0);
    endproperty
    a_null: assert property (p_null) else $error("null flag wrong");
    property p_sxor;
        op_valid && op_code inside {OP_ADD, OP_ADC, OP_SUB, OP_SBC}
            |=> flags_out[7] == (flags_out[3] ^ result_out[7]);
    endproperty
    a_sxor: assert property (p_sxor) else $error("sign xor wrong");
    property p_ovf;
        op_valid && op_code inside {OP_ADD, OP_ADC} |=> flags_out[3] ==
            (($past(op_a[7]) == $past(op_b[7])) && (result_out[7] != $past(op_a[7])));
    endproperty
    a_ovf: assert property (p_ovf) else $error("range flag wrong");
    property p_carry;
        op_valid && op_code == OP_ADD |=> flags_out[0] ==
            ({1'b0, $past(op_a)} + $past(op_b) > 9'h0ff);
    endproperty
    a_carry: assert property (p_carry) else $error("carry wrong");
    property p_czsub; op_valid && op_code == OP_SUB |=> flags_out[6] == flags_out[2]; endproperty
    a_czsub: assert property (p_czsub) else $error("compound null wrong");
    property p_rd;
        reg_re && reg_addr == PROCESSOR_FLAGS_OFFSET |=> reg_rdata == $past(flags_out);
    endproperty
    a_rd: assert property (p_rd) else $error("read data wrong");
    // Main scenarios reached
    c_sbc: cover property (op_valid && op_code == OP_SBC);
    c_sleep: cover property (sleep_instr && watchdog_timeout);
    c_wr_rd: cover property (reg_we ##2 reg_re);
endmodule // cpu_status_flags_monitor

bind cpu_status_flags cpu_status_flags_monitor #(.ADDR_WIDTH(ADDR_WIDTH))
    cpu_status_flags_monitor_i (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .op_valid(op_valid), .op_code(op_code),
    .op_a(op_a), .op_b(op_b), .result_out(result_out), .result_valid(result_valid),
    .kick_watchdog_instr(kick_watchdog_instr), .sleep_instr(sleep_instr),
    .watchdog_timeout(watchdog_timeout), .flags_out(flags_out));

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps

module tb_top;
    import cpu_flags_pkg::*;
    typedef struct {alu_op_t op; logic [7:0] a; logic [7:0] b;
        logic [7:0] r; logic [7:0] f;} row_t;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_we = 1'b0;
    logic reg_re = 1'b0;
    logic [7:0] reg_rdata, result_out, flags_out, op_a, op_b;
    logic result_valid, op_valid;
    logic [2:0] evt;
    alu_op_t op_code;
    int miscompares = 0;
    int checks = 0;
    // Rows chain: carry and compound flag carry over from the row before
    row_t rows [12] = '{
        '{OP_ADD, 8'h7f, 8'h01, 8'h80, 8'h0a}, '{OP_ADD, 8'hff, 8'h01, 8'h00, 8'h07},
        '{OP_ADC, 8'h00, 8'h00, 8'h01, 8'h00}, '{OP_SUB, 8'h05, 8'h05, 8'h00, 8'h47},
        '{OP_SBC, 8'h03, 8'h03, 8'h00, 8'h47}, '{OP_SBC, 8'h00, 8'h01, 8'hff, 8'h80},
        '{OP_RLC, 8'h81, 8'h00, 8'h02, 8'h81}, '{OP_RRC, 8'h02, 8'h00, 8'h81, 8'h80},
        '{OP_AND, 8'hf0, 8'h0f, 8'h00, 8'h84}, '{OP_OR, 8'h10, 8'h01, 8'h11, 8'h80},
        '{OP_XOR, 8'h5a, 8'h5a, 8'h00, 8'h84}, '{OP_ADD, 8'h08, 8'h08, 8'h10, 8'h02}};
    // Bit 8 picks event pulse over software write
    logic [8:0] stp [9] = '{9'h0ff, 9'h102, 9'h104, 9'h000, 9'h101,
        9'h104, 9'h106, 9'h101, 9'h102};
    logic [7:0] sx [9] = '{8'hcf, 8'hdf, 8'hff, 8'h30, 8'h00, 8'h20, 8'h30, 8'h00, 8'h10};

    cpu_status_flags cpu_status_flags_i (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
        .op_valid(op_valid), .op_code(op_code), .op_a(op_a), .op_b(op_b),
        .result_out(result_out), .result_valid(result_valid), .kick_watchdog_instr(evt[0]),
        .sleep_instr(evt[1]), .watchdog_timeout(evt[2]), .flags_out(flags_out));
    exec_model exec_model_i (.clk(clk), .op_valid(op_valid), .op_code(op_code), .op_a(op_a),
        .op_b(op_b), .evt(evt));

    initial begin
        forever #25 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin
            $display("MISMATCH %s expected %h seen %h", n, e, s);
            miscompares++;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_we <= 1'b0;
        reg_wdata <= ~d; // Write data is not trusted after the strobe
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_re <= 1'b0;
        #1;
        chk("rdata", reg_rdata, e);
    endtask
    task automatic results;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (3000) @(posedge clk);
        miscompares++;
        results();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        #1;
        chk("flags_rst", flags_out, 8'h00);
        chk("rdata_rst", reg_rdata, 8'h00);
        $display("test reset done");
        foreach (rows[i]) begin
            exec_model_i.issue(rows[i].op, rows[i].a, rows[i].b);
            #1;
            chk("valid", {7'h00, result_valid}, 8'h01);
            chk("result", result_out, rows[i].r);
            chk("flags", flags_out, rows[i].f);
        end
        $display("test rows done");
        // No-op code leaves everything alone
        exec_model_i.issue(OP_NONE, 8'h01, 8'h01);
        #1;
        chk("none_valid", {7'h00, result_valid}, 8'h00);
        chk("none_flags", flags_out, 8'h02);
        $display("test refused op done");
        // Sleep with timeout in one cycle: timeout wins its bit
        foreach (stp[i]) begin
            if (stp[i][8]) exec_model_i.pulse(stp[i][2:0]);
            else wr(4'h0, stp[i][7:0]);
            #1;
            chk("flags_sw", flags_out, sx[i]);
        end
        $display("test events done");
        rd(4'h0, 8'h10);
        wr(4'h1, 8'h55);
        #1;
        chk("ro_write", flags_out, 8'h10);
        rd(4'h1, 8'h10);
        rd(4'h5, 8'h00);
        @(posedge clk);
        #1;
        chk("rdata_idle", reg_rdata, 8'h00);
        $display("test register map done");
        // Mid-run reset must clear both flags that software cannot write
        exec_model_i.pulse(3'b100);
        #1;
        chk("flags_pre_rst", flags_out, 8'h30);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        #1;
        chk("flags_rst2", flags_out, 8'h00);
        $display("test mid-run reset done");
        results();
    end
endmodule // tb_top
